// file: hw/fdcpin_pkg.sv
// fdcpin_pkg: constants and types for the floppy controller pin block
// assumes a 10 MHz system clock and synchronous pin inputs
package fdcpin_pkg;
	// ------------------------------------------------------------
	// register selects
	// ------------------------------------------------------------
	localparam logic [1:0] FDC_SEL_STATUS_CMD = 2'h0;
	localparam logic [1:0] FDC_SEL_TRACK = 2'h1;
	localparam logic [1:0] FDC_SEL_SECTOR = 2'h2;
	localparam logic [1:0] FDC_SEL_DATA = 2'h3;
	// ------------------------------------------------------------
	// reset values and fields
	// ------------------------------------------------------------
	localparam logic [7:0] FDC_CMD_RESET = 8'h03;
	localparam logic [7:0] FDC_SECTOR_RESET = 8'h01;
	localparam logic [7:0] FDC_ZERO_BYTE = 8'h00;
	localparam logic [7:0] FDC_ONES_BYTE = 8'hFF;
	localparam int FDC_ST_NOT_READY = 7;
	localparam int FDC_ST_WPROT = 6;
	localparam int FDC_ST_RNF = 4;
	localparam int FDC_ST_LOST = 2;
	localparam int FDC_ST_DRQ = 1;
	localparam int FDC_ST_BUSY = 0;
	localparam logic [7:0] FDC_TRACK_ZONE_LO = 8'h2C;
	localparam logic [7:0] FDC_TRACK_ZONE_HI = 8'h4C;
	// command decode: upper nibble opcodes, side select in bit 3
	localparam logic [3:0] FDC_OP_RESTORE = 4'h0;
	localparam logic [3:0] FDC_OP_SEEK = 4'h1;
	localparam logic [3:0] FDC_OP_STEP_IN = 4'h5;
	localparam logic [3:0] FDC_OP_STEP_OUT = 4'h7;
	localparam logic [3:0] FDC_OP_READ = 4'h8;
	localparam logic [3:0] FDC_OP_WRITE = 4'hA;
	localparam int FDC_SIDE_BIT = 3;
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int FDC_CLK_HZ = 10_000_000;
	localparam int FDC_CLK_NS = 1_000_000_000 / FDC_CLK_HZ;
	localparam int FDC_RESET_US = 50;
	localparam int FDC_RESET_CYC = FDC_RESET_US * 1000 / FDC_CLK_NS;
	localparam int FDC_WD_MFM_NS = 200;
	localparam int FDC_WD_FM_NS = 500;
	localparam int FDC_WD_MFM_CYC = FDC_WD_MFM_NS / FDC_CLK_NS;
	localparam int FDC_WD_FM_CYC = FDC_WD_FM_NS / FDC_CLK_NS;
	localparam int FDC_STEP_CYC = 20;
	localparam int FDC_BYTE_CYC = 160;
	localparam int FDC_SYNC_MFM = 4;
	localparam int FDC_SYNC_FM = 2;
	localparam int FDC_PLL_GAP_MFM = 8;
	localparam int FDC_PLL_GAP_FM = 4;
	localparam int FDC_SECTOR_BYTES = 128;
	localparam int FDC_ID_CRC_BYTE = 5;
	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef struct packed {
		logic step;
		logic step_direction;
		logic head_load_out;
		logic write_gate;
		logic write_flux_out;
		logic early;
		logic late;
		logic read_sync_gate;
		logic side_select_out;
		logic outer_track_zone;
	} fdcpin_drive_t;
	typedef enum logic [2:0] {
		FDC_IDLE,
		FDC_STEPPING,
		FDC_SETTLE,
		FDC_SYNC,
		FDC_ID,
		FDC_XFER,
		FDC_DONE
	} fdcpin_state_t;
endpackage

// file: hw/fdcpin_core.sv
// fdcpin_core: host register port and drive pin sequencer
// assumes synchronous inputs, one clock, external pull-ups on open drains
`timescale 1ns/1ps
module fdcpin_core #(
	parameter int RESET_CYC = fdcpin_pkg::FDC_RESET_CYC,
	parameter int BYTE_CYC = fdcpin_pkg::FDC_BYTE_CYC,
	parameter int SECTOR_BYTES = fdcpin_pkg::FDC_SECTOR_BYTES
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic master_reset_n_i,
	input wire logic chip_select_n_i,
	input wire logic read_strobe_n_i,
	input wire logic write_strobe_n_i,
	input wire logic reg_select_lo_i,
	input wire logic reg_select_hi_i,
	input wire logic [7:0] host_data_bus_i,
	output logic [7:0] host_data_bus_o,
	output logic host_data_bus_oe_o,
	output logic data_request_o,
	output logic interrupt_request_o,
	input wire logic head_engaged_in_i,
	input wire logic track_zero_in_i,
	input wire logic index_pulse_in_i,
	input wire logic write_protect_in_i,
	input wire logic ready_in_i,
	input wire logic density_select_n_i,
	input wire logic raw_read_n_i,
	input wire logic [7:0] read_byte_i,
	input wire logic read_byte_valid_i,
	input wire logic id_side_i,
	input wire logic fault_or_pll_enable_i,
	output logic fault_or_pll_enable_o,
	output logic fault_or_pll_enable_oe_o,
	output fdcpin_pkg::fdcpin_drive_t drive_o
);
	import fdcpin_pkg::*;
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	fdcpin_state_t state, next_state;
	logic [7:0] command_code, next_command_code;
	logic [7:0] head_track_number, next_head_track_number;
	logic [7:0] target_sector_number, next_target_sector_number;
	logic [7:0] transfer_byte, next_transfer_byte;
	logic [7:0] status_flags, next_status_flags;
	logic [7:0] shift_byte, next_shift_byte;
	logic [15:0] timer, next_timer;
	logic [15:0] mr_count, next_mr_count;
	logic [10:0] bytes, next_bytes;
	logic [3:0] sync_count, next_sync_count;
	logic mr_done, next_mr_done;
	logic in_reset, next_in_reset;
	logic data_request, next_drq;
	logic irq, next_irq;
	logic full, next_full;
	logic writing, next_writing;
	logic [7:0] rd_data, next_rd_data;
	logic rd_oe, next_rd_oe;
	logic pll_n, next_pll_n;
	logic pll_oe, next_pll_oe;
	logic rd_prev, next_rd_prev;
	logic wr_prev, next_wr_prev;
	fdcpin_drive_t drv, next_drv;
	logic rd_edge, wr_edge, sel, mfm, rnf_hit, fault_n;
	logic [3:0] op;
	logic [15:0] wd_len;

	assign sel = !chip_select_n_i;
	assign rd_edge = sel && !read_strobe_n_i && rd_prev;
	assign wr_edge = sel && !write_strobe_n_i && wr_prev;
	assign op = command_code[7:4];
	// density select decode
	// low selects MFM
	assign mfm = !density_select_n_i;
	assign wd_len = mfm ? 16'(FDC_WD_MFM_CYC) : 16'(FDC_WD_FM_CYC);
	// fault input only while write gate high
	assign fault_n = drv.write_gate ? fault_or_pll_enable_i : 1'b1;
	assign rnf_hit = read_byte_valid_i && state == FDC_ID &&
		(id_side_i != drv.side_select_out);

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb
	begin
		next_state = state;
		next_command_code = command_code;
		next_head_track_number = head_track_number;
		next_target_sector_number = target_sector_number;
		next_transfer_byte = transfer_byte;
		next_status_flags = status_flags;
		next_shift_byte = shift_byte;
		next_timer = timer;
		next_mr_count = mr_count;
		next_mr_done = mr_done;
		next_in_reset = in_reset;
		next_bytes = bytes;
		next_sync_count = sync_count;
		next_drq = data_request;
		next_irq = irq;
		next_full = full;
		next_writing = writing;
		next_rd_prev = read_strobe_n_i;
		next_wr_prev = write_strobe_n_i;
		next_pll_n = pll_n;
		next_drv = drv;
		next_drv.step = 1'b0;
		next_drv.early = 1'b0;
		next_drv.late = 1'b0;
		next_rd_oe = sel && !read_strobe_n_i;
		case ({reg_select_hi_i, reg_select_lo_i})
			FDC_SEL_STATUS_CMD: next_rd_data = status_flags;
			FDC_SEL_TRACK: next_rd_data = head_track_number;
			FDC_SEL_SECTOR: next_rd_data = target_sector_number;
			default: next_rd_data = transfer_byte;
		endcase
		if (timer != 16'h0000)
			next_timer = timer - 16'h0001;
		next_drv.outer_track_zone = (op == FDC_OP_READ || op == FDC_OP_WRITE)
			&& head_track_number >= FDC_TRACK_ZONE_LO
			&& head_track_number <= FDC_TRACK_ZONE_HI;
		// inverse of ready shown in status
		next_status_flags[FDC_ST_NOT_READY] = !ready_in_i;
		next_status_flags[FDC_ST_DRQ] = data_request;
		next_status_flags[FDC_ST_BUSY] = state != FDC_IDLE;
		if (rd_edge)
		begin
			case ({reg_select_hi_i, reg_select_lo_i})
				FDC_SEL_STATUS_CMD: next_irq = 1'b0;
				FDC_SEL_DATA:
				begin
					next_drq = 1'b0;
					next_full = 1'b0;
				end
				default: ;
			endcase
		end
		if (wr_edge)
		begin
			case ({reg_select_hi_i, reg_select_lo_i})
				FDC_SEL_STATUS_CMD:
				begin
					next_irq = 1'b0;
					next_command_code = host_data_bus_i;
					next_status_flags[FDC_ST_LOST] = 1'b0;
					next_status_flags[FDC_ST_RNF] = 1'b0;
					next_status_flags[FDC_ST_WPROT] = 1'b0;
					next_state = FDC_STEPPING;
					next_bytes = 11'h000;
					next_sync_count = 4'h0;
					// side latched only at command start
					if (host_data_bus_i[7] == 1'b1)
						next_drv.side_select_out =
							host_data_bus_i[FDC_SIDE_BIT];
				end
				FDC_SEL_TRACK: next_head_track_number = host_data_bus_i;
				FDC_SEL_SECTOR: next_target_sector_number = host_data_bus_i;
				default:
				begin
					next_transfer_byte = host_data_bus_i;
					next_drq = 1'b0;
					next_full = 1'b1;
				end
			endcase
		end
		// ------------------------------------------------------------
		// sequencer
		// ------------------------------------------------------------
		case (state)
			FDC_IDLE: ;
			FDC_STEPPING:
			begin
				if (op[3])
				begin
					if (!ready_in_i)
						next_state = FDC_DONE;
					else if (op == FDC_OP_WRITE && !write_protect_in_i)
					begin
						next_status_flags[FDC_ST_WPROT] = 1'b1;
						next_state = FDC_DONE;
					end
					else
					begin
						next_drv.head_load_out = 1'b1;
						next_state = FDC_SETTLE;
					end
				end
				else if (timer == 16'h0000)
				begin
					if ((op == FDC_OP_RESTORE && !track_zero_in_i) ||
						(op == FDC_OP_SEEK &&
						transfer_byte != head_track_number) ||
						op == FDC_OP_STEP_IN || op == FDC_OP_STEP_OUT)
					begin
						next_drv.step = 1'b1;
						next_drv.step_direction = op == FDC_OP_STEP_IN ||
							(op == FDC_OP_SEEK &&
							transfer_byte > head_track_number);
						next_head_track_number = next_drv.step_direction ?
							head_track_number + 8'h01 :
							head_track_number - 8'h01;
						next_timer = 16'(FDC_STEP_CYC);
						if (op == FDC_OP_STEP_IN || op == FDC_OP_STEP_OUT)
							next_state = FDC_DONE;
					end
					else
					begin
						if (op == FDC_OP_RESTORE)
							next_head_track_number = FDC_ZERO_BYTE;
						next_state = FDC_DONE;
					end
				end
			end
			FDC_SETTLE:
			begin
				if (head_engaged_in_i)
				begin
					next_writing = op == FDC_OP_WRITE;
					next_drv.write_gate = op == FDC_OP_WRITE;
					// pll enable low after head settled for reads, high for writes
					next_pll_n = op == FDC_OP_WRITE;
					next_timer = 16'(BYTE_CYC);
					next_drq = op == FDC_OP_WRITE;
					next_state = op == FDC_OP_WRITE ? FDC_XFER : FDC_SYNC;
				end
			end
			FDC_SYNC:
			begin
				if (read_byte_valid_i)
				begin
					if (read_byte_i == FDC_ZERO_BYTE ||
						(mfm && read_byte_i == FDC_ONES_BYTE))
						next_sync_count = sync_count + 4'h1;
					else
						next_sync_count = 4'h0;
					if (int'(sync_count) + 1 >=
						(mfm ? FDC_SYNC_MFM : FDC_SYNC_FM))
					begin
						next_drv.read_sync_gate = 1'b1;
						next_state = FDC_ID;
						next_bytes = 11'h000;
					end
				end
			end
			FDC_ID:
			begin
				if (rnf_hit)
				begin
					next_status_flags[FDC_ST_RNF] = 1'b1;
					next_state = FDC_DONE;
				end
				else if (read_byte_valid_i)
				begin
					next_bytes = bytes + 11'h001;
					// pll off after id crc until gap ahead of mark
					if (int'(bytes) == FDC_ID_CRC_BYTE)
						next_pll_n = 1'b1;
					if (int'(bytes) == FDC_ID_CRC_BYTE +
						(mfm ? FDC_PLL_GAP_MFM : FDC_PLL_GAP_FM))
					begin
						next_pll_n = 1'b0;
						next_bytes = 11'h000;
						next_state = FDC_XFER;
					end
				end
			end
			FDC_XFER:
			begin
				if (!writing && read_byte_valid_i)
				begin
					// overwrite of unread byte sets lost data
					if (full)
						next_status_flags[FDC_ST_LOST] = 1'b1;
					next_transfer_byte = read_byte_i;
					next_full = 1'b1;
					next_drq = 1'b1;
					next_bytes = bytes + 11'h001;
				end
				if (writing && timer == 16'h0000)
				begin
					if (!full || data_request)
					begin
						next_shift_byte = FDC_ZERO_BYTE;
						next_status_flags[FDC_ST_LOST] = 1'b1;
					end
					else
						next_shift_byte = transfer_byte;
					next_full = 1'b0;
					next_drq = 1'b1;
					next_timer = 16'(BYTE_CYC);
					next_bytes = bytes + 11'h001;
				end
				if (writing)
				begin
					// pulse width by density; precomp during pulse
					next_drv.write_flux_out = timer > 16'(BYTE_CYC) - wd_len;
					next_drv.early = next_drv.write_flux_out && shift_byte[7];
					next_drv.late = next_drv.write_flux_out && shift_byte[0];
				end
				if (int'(bytes) >= SECTOR_BYTES || !fault_n)
					next_state = FDC_DONE;
			end
			FDC_DONE:
			begin
				next_drv.write_gate = 1'b0;
				next_drv.write_flux_out = 1'b0;
				next_drv.read_sync_gate = 1'b0;
				next_drv.head_load_out = 1'b0;
				next_pll_n = 1'b1;
				next_writing = 1'b0;
				next_drq = 1'b0;
				next_irq = 1'b1;
				next_state = FDC_IDLE;
			end
			default: next_state = FDC_IDLE;
		endcase
		// master reset after minimum low time
		if (!master_reset_n_i)
		begin
			next_mr_count = (mr_count < 16'(RESET_CYC)) ?
				mr_count + 16'h0001 : mr_count;
			if (mr_count + 16'h0001 >= 16'(RESET_CYC))
				next_mr_done = 1'b1;
			next_in_reset = 1'b1;
			next_status_flags[FDC_ST_NOT_READY] = 1'b0;
			if (mr_done)
			begin
				next_command_code = FDC_CMD_RESET;
				next_state = FDC_IDLE;
				next_drq = 1'b0;
				next_irq = 1'b0;
				next_drv = '0;
				next_writing = 1'b0;
				next_pll_n = 1'b1;
			end
		end
		else
		begin
			next_mr_count = 16'h0000;
			next_in_reset = 1'b0;
			next_mr_done = 1'b0;
			if (in_reset && mr_done)
			begin
				next_state = FDC_STEPPING;
				next_target_sector_number = FDC_SECTOR_RESET;
			end
		end
		// shared pin driven only while not writing
		next_pll_oe = !next_writing;
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state <= FDC_IDLE;
			command_code <= FDC_CMD_RESET;
			head_track_number <= FDC_ZERO_BYTE;
			target_sector_number <= FDC_SECTOR_RESET;
			transfer_byte <= FDC_ZERO_BYTE;
			status_flags <= FDC_ZERO_BYTE;
			shift_byte <= FDC_ZERO_BYTE;
			timer <= 16'h0000;
			mr_count <= 16'h0000;
			mr_done <= 1'b0;
			in_reset <= 1'b0;
			bytes <= 11'h000;
			sync_count <= 4'h0;
			data_request <= 1'b0;
			irq <= 1'b0;
			full <= 1'b0;
			writing <= 1'b0;
			rd_data <= FDC_ZERO_BYTE;
			rd_oe <= 1'b0;
			pll_n <= 1'b1;
			pll_oe <= 1'b1;
			rd_prev <= 1'b1;
			wr_prev <= 1'b1;
			drv <= '0;
		end
		else
		begin
			state <= next_state;
			command_code <= next_command_code;
			head_track_number <= next_head_track_number;
			target_sector_number <= next_target_sector_number;
			transfer_byte <= next_transfer_byte;
			status_flags <= next_status_flags;
			shift_byte <= next_shift_byte;
			timer <= next_timer;
			mr_count <= next_mr_count;
			mr_done <= next_mr_done;
			in_reset <= next_in_reset;
			bytes <= next_bytes;
			sync_count <= next_sync_count;
			data_request <= next_drq;
			irq <= next_irq;
			full <= next_full;
			writing <= next_writing;
			rd_data <= next_rd_data;
			rd_oe <= next_rd_oe;
			pll_n <= next_pll_n;
			pll_oe <= next_pll_oe;
			rd_prev <= next_rd_prev;
			wr_prev <= next_wr_prev;
			drv <= next_drv;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign host_data_bus_o = rd_data;
	assign host_data_bus_oe_o = rd_oe;
	// active-high request levels for open-drain pads
	assign data_request_o = data_request;
	assign interrupt_request_o = irq;
	assign fault_or_pll_enable_o = pll_n;
	assign fault_or_pll_enable_oe_o = pll_oe;
	assign drive_o = drv;
endmodule

// file: sim/fdcpin_chk.sv
// fdcpin_chk: port assertions for fdcpin_core
// assumes binding to fdcpin_core, one clock, sync reset rst_i
`timescale 1ns/1ps
module fdcpin_chk
	import fdcpin_pkg::*;
#(
	parameter int RESET_CYC = 500
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic master_reset_n_i,
	input wire logic chip_select_n_i,
	input wire logic read_strobe_n_i,
	input wire logic write_strobe_n_i,
	input wire logic reg_select_lo_i,
	input wire logic reg_select_hi_i,
	input wire logic [7:0] host_data_bus_i,
	input wire logic host_data_bus_oe_o,
	input wire logic data_request_o,
	input wire logic interrupt_request_o,
	input wire logic ready_in_i,
	input wire logic write_protect_in_i,
	input wire logic density_select_n_i,
	input wire logic track_zero_in_i,
	input wire logic fault_or_pll_enable_oe_o,
	input wire fdcpin_pkg::fdcpin_drive_t drive_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	int mr_cnt;
	int next_mr_cnt;
	logic cmd_sel;
	assign cmd_sel = !chip_select_n_i && !reg_select_hi_i && !reg_select_lo_i;
	always_comb
	begin
		next_mr_cnt = mr_cnt;
		if (master_reset_n_i)
			next_mr_cnt = 0;
		else if (mr_cnt < 100000)
			next_mr_cnt = mr_cnt + 1;
	end
	always_ff @(posedge clk_i)
	begin
		mr_cnt <= next_mr_cnt;
	end
	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	a_mr_quiet: assert property (!master_reset_n_i && mr_cnt >= RESET_CYC + 3
		|-> drive_o == '0 && !data_request_o && !interrupt_request_o)
		else $error("outputs active during master reset");
	a_restore_start: assert property ($rose(master_reset_n_i) && !track_zero_in_i
		&& mr_cnt >= RESET_CYC |-> ##[1:40] (drive_o.step && !drive_o.step_direction))
		else $error("no outward step after master reset");
	a_oe_read: assert property (!chip_select_n_i && !read_strobe_n_i
		|=> host_data_bus_oe_o)
		else $error("bus not driven on read");
	a_oe_idle: assert property (chip_select_n_i |=> !host_data_bus_oe_o)
		else $error("bus driven while deselected");
	a_step_pulse: assert property ($rose(drive_o.step)
		|=> !drive_o.step [*8])
		else $error("step pulse too long or too close");
	a_irq_cmd: assert property ($fell(write_strobe_n_i) && cmd_sel
		|=> !interrupt_request_o)
		else $error("irq kept after command write");
	a_irq_status: assert property ($fell(read_strobe_n_i) && cmd_sel
		|-> ##[1:2] !interrupt_request_o)
		else $error("irq kept after status read");
	a_fault_dir: assert property (drive_o.write_gate
		|-> ##[0:1] !fault_or_pll_enable_oe_o)
		else $error("shared pin driven while writing");
	a_flux_fm: assert property ($rose(drive_o.write_flux_out) && density_select_n_i
		|-> drive_o.write_flux_out [*5] ##1 !drive_o.write_flux_out)
		else $error("single density flux pulse width");
	a_flux_mfm: assert property ($rose(drive_o.write_flux_out) && !density_select_n_i
		|-> drive_o.write_flux_out [*2] ##1 !drive_o.write_flux_out)
		else $error("double density flux pulse width");
	a_ready_skip: assert property ($fell(write_strobe_n_i) && cmd_sel
		&& host_data_bus_i[7:4] == 4'h8 && !ready_in_i
		|-> ##[2:40] interrupt_request_o)
		else $error("no interrupt for read with drive not ready");
	a_wprot_stop: assert property ($fell(write_strobe_n_i) && cmd_sel
		&& host_data_bus_i[7:4] == 4'hA && !write_protect_in_i && ready_in_i
		|-> !drive_o.write_gate throughout (##[2:40] interrupt_request_o))
		else $error("protected write not stopped");
	c_restore: cover property ($rose(master_reset_n_i) ##[1:40] drive_o.step);
	c_sync: cover property ($rose(drive_o.read_sync_gate));
	c_wprot: cover property ($fell(write_strobe_n_i) && !write_protect_in_i);
endmodule

bind fdcpin_core fdcpin_chk #(.RESET_CYC(RESET_CYC)) u_chk (.clk_i, .rst_i,
	.master_reset_n_i, .chip_select_n_i, .read_strobe_n_i, .write_strobe_n_i,
	.reg_select_lo_i, .reg_select_hi_i, .host_data_bus_i, .host_data_bus_oe_o,
	.data_request_o, .interrupt_request_o, .ready_in_i, .write_protect_in_i,
	.density_select_n_i, .track_zero_in_i, .fault_or_pll_enable_oe_o,
	.drive_o);

// file: sim/fdcpin_drive_model.sv
// fdcpin_drive_model: behavioural floppy drive on the pin struct
// assumes head starts on track 3 and decoded bytes every 16 cycles
`timescale 1ns/1ps
module fdcpin_drive_model
	import fdcpin_pkg::*;
(
	input wire logic clk_i,
	input wire fdcpin_pkg::fdcpin_drive_t drive_i,
	output logic head_engaged_in_o,
	output logic track_zero_in_o,
	output logic [7:0] read_byte_o,
	output logic read_byte_valid_o,
	output int pos_o,
	output int steps_o,
	output logic last_dir_o
);
	int tick = 0;
	initial
	begin
		pos_o = 3;
		steps_o = 0;
		last_dir_o = 1'b0;
		head_engaged_in_o = 1'b0;
	end
	assign track_zero_in_o = (pos_o == 0);
	// ------------------------------------------------------------
	// head motion and media stream
	// ------------------------------------------------------------
	always @(posedge clk_i)
	begin
		head_engaged_in_o <= drive_i.head_load_out;
		tick <= (tick + 1) % 16;
		if (drive_i.step)
		begin
			steps_o <= steps_o + 1;
			last_dir_o <= drive_i.step_direction;
			pos_o <= drive_i.step_direction ? pos_o + 1 : pos_o - 1;
		end
	end
	assign read_byte_valid_o = (tick == 0);
	assign read_byte_o = read_byte_valid_o ? 8'h00 : 8'hFF;
endmodule

// file: sim/testbench.sv
// testbench: self-checking bench for fdcpin_core with drive model
// assumes 10 MHz clock and shortened master reset count
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin \
	n_mismatch++; $display("Error %0t: got %h want %h", $time, a, e); end end
module testbench;
	import fdcpin_pkg::*;
	logic clk_i = 0;
	logic rst_i = 1;
	logic mr_n = 1;
	logic cs_n = 1;
	logic rd_n = 1;
	logic wr_n = 1;
	logic [1:0] sel = 2'h0;
	logic [7:0] dat = 8'h00;
	logic wp = 1;
	logic rdy = 1;
	logic dens = 0;
	logic wf_n = 1;
	logic zone;
	logic [7:0] bus_o, rbyte, q;
	logic bus_oe, data_request, irq, hl, tz, rvalid, pll_o, pll_oe, fault_w;
	fdcpin_drive_t drv;
	int pos, steps, n_mismatch, check_count, seed, i, a;
	logic ldir;
	logic [7:0] exp_reg [4];
	always #50 clk_i = ~clk_i;
	assign fault_w = pll_oe ? pll_o : wf_n;
	fdcpin_core #(.RESET_CYC(5)) DUT (.clk_i, .rst_i, .master_reset_n_i(mr_n),
		.chip_select_n_i(cs_n), .read_strobe_n_i(rd_n),
		.write_strobe_n_i(wr_n), .reg_select_lo_i(sel[0]),
		.reg_select_hi_i(sel[1]), .host_data_bus_i(dat), .host_data_bus_o(bus_o),
		.host_data_bus_oe_o(bus_oe), .data_request_o(data_request),
		.interrupt_request_o(irq), .head_engaged_in_i(hl), .track_zero_in_i(tz),
		.index_pulse_in_i(1'b0), .write_protect_in_i(wp), .ready_in_i(rdy),
		.density_select_n_i(dens), .raw_read_n_i(1'b1), .read_byte_i(rbyte),
		.read_byte_valid_i(rvalid), .id_side_i(1'b0),
		.fault_or_pll_enable_i(fault_w), .fault_or_pll_enable_o(pll_o),
		.fault_or_pll_enable_oe_o(pll_oe), .drive_o(drv));
	fdcpin_drive_model u_drive (.clk_i, .drive_i(drv), .head_engaged_in_o(hl),
		.track_zero_in_o(tz), .read_byte_o(rbyte), .read_byte_valid_o(rvalid),
		.pos_o(pos), .steps_o(steps), .last_dir_o(ldir));
	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic bus(input bit rd, input logic [1:0] s, input logic [7:0] d);
		@(posedge clk_i);
		#2;
		cs_n = 0;
		rd_n = !rd;
		wr_n = rd;
		sel = s;
		dat = d;
		@(posedge clk_i);
		@(posedge clk_i);
		#2;
		q = bus_o;
		cs_n = 1;
		rd_n = 1;
		wr_n = 1;
		@(posedge clk_i);
		#2;
	endtask
	task automatic wait_irq(input int lim);
		for (i = 0; i < lim && irq !== 1'b1; i++)
		begin
			@(posedge clk_i);
			#2;
		end
		`CHK(irq, 1'b1)
	endtask
	task automatic mr_pulse();
		@(posedge clk_i);
		#2;
		mr_n = 0;
		repeat (10) @(posedge clk_i);
		#2;
		`CHK(drv.side_select_out, 1'b0)
		mr_n = 1;
		wait_irq(300);
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial
	begin
		#2_000_000;
		n_mismatch++;
		results();
	end
	initial
	begin
		seed = 77318;
		repeat (6) @(posedge clk_i);
		#2;
		rst_i = 0;
		mr_pulse();
		`CHK(pos, 0)
		`CHK(steps, 3)
		bus(1, FDC_SEL_SECTOR, 8'h00);
		`CHK(q, FDC_SECTOR_RESET)
		bus(1, FDC_SEL_STATUS_CMD, 8'h00);
		`CHK(q[FDC_ST_NOT_READY], 1'b0)
		`CHK(irq, 1'b0)
		$display("test restore done");
		exp_reg[1] = FDC_ZERO_BYTE;
		exp_reg[2] = FDC_SECTOR_RESET;
		exp_reg[3] = FDC_ZERO_BYTE;
		for (int k = 0; k < 8; k++)
		begin
			a = $unsigned($random(seed)) % 3 + 1;
			exp_reg[a] = 8'($random(seed));
			bus(0, 2'(a), exp_reg[a]);
			bus(1, 2'(a), 8'h00);
			`CHK(q, exp_reg[a])
		end
		for (int k = 1; k < 4; k++)
		begin
			bus(1, 2'(k), 8'h00);
			`CHK(q, exp_reg[k])
		end
		$display("test registers done");
		bus(0, FDC_SEL_STATUS_CMD, 8'h50);
		wait_irq(100);
		`CHK(pos, 1)
		`CHK(ldir, 1'b1)
		bus(0, FDC_SEL_STATUS_CMD, 8'h70);
		wait_irq(100);
		`CHK(pos, 0)
		`CHK(ldir, 1'b0)
		$display("test stepping done");
		rdy = 0;
		bus(0, FDC_SEL_STATUS_CMD, 8'h80);
		wait_irq(100);
		bus(1, FDC_SEL_STATUS_CMD, 8'h00);
		`CHK(q[FDC_ST_NOT_READY], 1'b1)
		rdy = 1;
		wp = 0;
		bus(0, FDC_SEL_STATUS_CMD, 8'hA0);
		wait_irq(100);
		bus(1, FDC_SEL_STATUS_CMD, 8'h00);
		`CHK(q[FDC_ST_WPROT], 1'b1)
		wp = 1;
		$display("test refusals done");
		zone = exp_reg[1] >= FDC_TRACK_ZONE_LO;
		zone = zone && exp_reg[1] <= FDC_TRACK_ZONE_HI;
		for (int k = 0; k < 2; k++)
		begin
			dens = k[0];
			bus(0, FDC_SEL_STATUS_CMD, 8'hA8);
			for (i = 0; i < 100 && data_request !== 1'b1; i++)
			begin
				@(posedge clk_i);
				#2;
			end
			`CHK(data_request, 1'b1)
			`CHK(drv.side_select_out, 1'b1)
			`CHK(drv.outer_track_zone, zone)
			`CHK(pll_oe, 1'b0)
			bus(0, FDC_SEL_DATA, 8'h81);
			`CHK(data_request, 1'b0)
			wf_n = 0;
			wait_irq(20);
			`CHK(drv.write_gate, 1'b0)
			wf_n = 1;
		end
		$display("test write done");
		for (int k = 0; k < 2; k++)
		begin
			dens = k[0];
			bus(0, FDC_SEL_STATUS_CMD, 8'h80);
			for (i = 0; i < 3000 && drv.read_sync_gate !== 1'b1; i++)
			begin
				@(posedge clk_i);
				#2;
			end
			`CHK(drv.read_sync_gate, 1'b1)
			`CHK(pll_o, 1'b0)
			mr_pulse();
		end
		$display("test read sync done");
		bus(0, FDC_SEL_STATUS_CMD, 8'h88);
		wait_irq(1000);
		bus(1, FDC_SEL_STATUS_CMD, 8'h00);
		`CHK(q[FDC_ST_RNF], 1'b1)
		$display("test side compare done");
		results();
	end
endmodule
